// ---- rtl/bru_pkg.sv ----
// package for the byte rotate unit: op codes, widths, carriers
// assumes one instruction clock; op decode done upstream
`default_nettype none
package bru_pkg;
  localparam int unsigned BRU_DW      = 8;
  localparam int unsigned BRU_MSB     = 7;
  localparam int unsigned BRU_LSB     = 0;
  localparam int unsigned BRU_OPW     = 3;
  localparam int unsigned BRU_LAT_CYC = 1;   // result registered one edge after request
  localparam logic [7:0]  BRU_BYTE_RST = 8'h00;
  localparam logic        BRU_CARRY_RST = 1'h0;

  // op codes presented on the request port; code 3'h7 is spare and refused
  typedef enum logic [2:0] {
    BRU_OP_NONE                                     = 3'h0,
    BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR               = 3'h1,
    BRU_OP_ROTATE_LEFT_THROUGH_CARRY                = 3'h2,
    BRU_OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACCUMULATOR = 3'h3,
    BRU_OP_ROTATE_RIGHT_IN_PLACE                    = 3'h4,
    BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR              = 3'h5,
    BRU_OP_ROTATE_RIGHT_THROUGH_CARRY               = 3'h6
  } bru_op_e;

  typedef struct packed {
    logic       valid;
    bru_op_e    op;
    logic [7:0] mem;
    logic       carry;
  } bru_req_s;

  typedef struct packed {
    logic       mem_we;
    logic       acc_we;
    logic       carry_we;
    logic [7:0] data;
    logic       carry;
  } bru_res_s;

  typedef struct packed {
    logic       done;
    bru_res_s   res;
  } bru_state_s;
endpackage : bru_pkg
`default_nettype wire

// ---- rtl/bru_rotator.sv ----
// combinational rotator core: one bit either way, optional carry
// assumes caller picks the inserted bit (own wrap or old carry)
`default_nettype none
module bru_rotator
  import bru_pkg::*;
(
  input  wire logic [7:0] i_data,
  input  wire logic       i_dir_right,
  input  wire logic       i_fill,
  output logic      [7:0] o_data,
  output logic            o_out_bit
);
  // out bit is the one that falls off the end
  always_comb begin
    if (i_dir_right) begin
      o_data    = {i_fill, i_data[BRU_MSB:1]};
      o_out_bit = i_data[BRU_LSB];
    end else begin
      o_data    = {i_data[BRU_MSB-1:0], i_fill};
      o_out_bit = i_data[BRU_MSB];
    end
  end
endmodule : bru_rotator
`default_nettype wire

// ---- rtl/bru_top.sv ----
// byte rotate datapath: six rotate variants, registered result
// assumes memory byte and carry are stable in the request cycle
`default_nettype none
module bru_top
  import bru_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  input  wire bru_req_s   i_req,
  output logic            o_done,
  output var bru_res_s    o_res
);
  // no architectural state here: memory, accumulator and carry live in the core,
  // which applies the enables below; only the result register sits in this unit
  // fill and out bits stay outside the rotator so the carry variants reuse it unchanged
  bru_state_s st_q;
  bru_state_s st_d;
  logic       dir_right;
  logic       thru_carry;
  logic       fill_bit;
  logic [7:0] rot_data;
  logic       out_bit;

  // decode helpers, used by datapath select and write enables
  // kept as functions so the datapath and the checks below decode ops the same way
  function automatic logic op_is_right(input bru_op_e op);
    return (op == BRU_OP_ROTATE_RIGHT_IN_PLACE) ||
           (op == BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_RIGHT_THROUGH_CARRY);
  endfunction : op_is_right

  function automatic logic op_is_carry(input bru_op_e op);
    return (op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY) ||
           (op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_RIGHT_THROUGH_CARRY);
  endfunction : op_is_carry

  function automatic logic op_to_acc(input bru_op_e op);
    return (op == BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR);
  endfunction : op_to_acc

  // the spare code (plain in-place left rotate) is refused just like the no-op code
  function automatic logic op_legal(input bru_op_e op);
    return (op == BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY) ||
           (op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_RIGHT_IN_PLACE) ||
           (op == BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR) ||
           (op == BRU_OP_ROTATE_RIGHT_THROUGH_CARRY);
  endfunction : op_legal

  // fill bit: own wrap bit for plain rotates, old carry for carry variants
  // decoding runs even when valid is low; the enables below gate the result
  always_comb begin
    dir_right  = op_is_right(i_req.op);
    thru_carry = op_is_carry(i_req.op);
    if (thru_carry) begin
      fill_bit = i_req.carry;
    end else if (dir_right) begin
      fill_bit = i_req.mem[BRU_LSB];
    end else begin
      fill_bit = i_req.mem[BRU_MSB];
    end
  end

  bru_rotator u_rot (
    .i_data      (i_req.mem),
    .i_dir_right (dir_right),
    .i_fill      (fill_bit),
    .o_data      (rot_data),
    .o_out_bit   (out_bit)
  );

  // next state: one request gives one result the next cycle, no stall
  // carry is echoed on plain rotates so a core that always loads it still sees no change
  // refused codes leave every enable low; data is don't-care but still follows the rotator
  always_comb begin
    st_d              = '0;
    st_d.res.data     = rot_data;
    st_d.res.carry    = i_req.carry;                            // untouched unless carry op
    if (i_req.valid && op_legal(i_req.op)) begin
      st_d.done         = 1'b1;
      st_d.res.acc_we   = op_to_acc(i_req.op);
      st_d.res.mem_we   = !op_to_acc(i_req.op);
      st_d.res.carry_we = thru_carry;
      if (thru_carry) begin
        st_d.res.carry = out_bit;
      end
    end
  end

  // register everything; outputs come straight from flops
  // a single registered stage keeps every rotate inside one instruction cycle of the core
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= '{done: 1'b0, res: '{mem_we: 1'b0, acc_we: 1'b0, carry_we: 1'b0,
                                   data: BRU_BYTE_RST, carry: BRU_CARRY_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // enables stand for one cycle only; the core must apply them at that edge
  assign o_done = st_q.done;
  assign o_res  = st_q.res;

  // checks: each one except chk_single_dest looks at the result one edge after the request was sampled
  // expected bytes are rebuilt from the sampled request, never from the rotator's own outputs
  // all are disabled while reset is low, so a mid-run reset leaves no false failure

  // left rotate to accumulator: bit 7 wraps to bit 0, memory and carry left alone
  chk_rl_acc_data: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && i_req.op == BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR) |=>
      (o_res.data == {$past(i_req.mem[6:0]), $past(i_req.mem[7])}) && o_res.acc_we && !o_res.mem_we
      && !o_res.carry_we)
    else $error("left rotate to acc wrong");

  // left through carry in place: old carry in at bit 0, bit 7 out to carry
  chk_left_carry_mem: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && i_req.op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY) |=>
      (o_res.data == {$past(i_req.mem[6:0]), $past(i_req.carry)}) && o_res.mem_we && !o_res.acc_we
      && o_res.carry_we && o_res.carry == $past(i_req.mem[7]))
    else $error("left through carry in place wrong");

  // left through carry to accumulator: same rotate, memory byte untouched
  chk_left_carry_acc: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && i_req.op == BRU_OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACCUMULATOR) |=>
      (o_res.data == {$past(i_req.mem[6:0]), $past(i_req.carry)}) && o_res.acc_we && !o_res.mem_we
      && o_res.carry_we && o_res.carry == $past(i_req.mem[7]))
    else $error("left through carry to acc wrong");

  // right rotate in place: bit 0 wraps to bit 7, carry left alone
  chk_right_mem: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && i_req.op == BRU_OP_ROTATE_RIGHT_IN_PLACE) |=>
      (o_res.data == {$past(i_req.mem[0]), $past(i_req.mem[7:1])}) && o_res.mem_we && !o_res.acc_we
      && !o_res.carry_we)
    else $error("right rotate in place wrong");

  // right rotate to accumulator: memory byte and carry untouched
  chk_right_acc: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && i_req.op == BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR) |=>
      (o_res.data == {$past(i_req.mem[0]), $past(i_req.mem[7:1])}) && o_res.acc_we && !o_res.mem_we
      && !o_res.carry_we)
    else $error("right rotate to acc wrong");

  // right through carry in place: old carry in at bit 7, bit 0 out to carry
  chk_right_carry_mem: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && i_req.op == BRU_OP_ROTATE_RIGHT_THROUGH_CARRY) |=>
      (o_res.data == {$past(i_req.carry), $past(i_req.mem[7:1])}) && o_res.mem_we && !o_res.acc_we
      && o_res.carry_we && o_res.carry == $past(i_req.mem[0]))
    else $error("right through carry in place wrong");

  // a taken request shows done on the very next edge; one edge later done is high only if the next request was taken
  chk_one_cycle_done: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_legal(i_req.op)) |=>
      o_done ##1 (o_done == $past(i_req.valid && op_legal(i_req.op))))
    else $error("rotate did not finish in one cycle");

  // the carry enable only ever follows a through-carry op
  chk_carry_only_flag: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_res.carry_we |-> o_done && $past(op_is_carry(i_req.op)))
    else $error("carry written by non-carry op");

  // exactly one destination per result, and none without done
  chk_single_dest: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(o_res.acc_we && o_res.mem_we) && ((o_res.acc_we || o_res.mem_we) == o_done))
    else $error("bad destination enables");

  // plain rotates must hand carry back exactly as it came in
  chk_flags_kept: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_legal(i_req.op) && !op_is_carry(i_req.op)) |=>
      !o_res.carry_we && (o_res.carry == $past(i_req.carry)))
    else $error("plain rotate touched carry");

  // refused requests: no done and no write enable of any kind
  chk_refused_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(i_req.valid && op_legal(i_req.op)) |=>
      !o_done && !o_res.mem_we && !o_res.acc_we && !o_res.carry_we)
    else $error("refused request gave a write");

  // accumulator variants never write the memory byte back
  chk_acc_keeps_mem: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_legal(i_req.op) && op_to_acc(i_req.op)) |=> o_res.acc_we && !o_res.mem_we)
    else $error("accumulator rotate wrote memory");

  // in-place variants always write back and leave the accumulator alone
  chk_mem_writeback: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_legal(i_req.op) && !op_to_acc(i_req.op)) |=> o_res.mem_we && !o_res.acc_we)
    else $error("in-place rotate missed write back");

  // left variants: the seven low bits move up one place whatever the fill
  chk_left_shift: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_legal(i_req.op) && !op_is_right(i_req.op)) |=>
      (o_res.data[7:1] == $past(i_req.mem[6:0])))
    else $error("left shift body wrong");

  // right variants: the seven high bits move down one place whatever the fill
  chk_right_shift: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_legal(i_req.op) && op_is_right(i_req.op)) |=>
      (o_res.data[6:0] == $past(i_req.mem[7:1])))
    else $error("right shift body wrong");

  // a result never appears without a request taken one edge before
  chk_done_has_req: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_done |-> $past(i_req.valid && op_legal(i_req.op)))
    else $error("done without a request");

  // the carry out is the bit that falls off: bit 7 going left, bit 0 going right
  chk_carry_out_bit: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_req.valid && op_is_carry(i_req.op)) |=>
      o_res.carry_we && (o_res.carry == ($past(op_is_right(i_req.op)) ?
                                         $past(i_req.mem[0]) : $past(i_req.mem[7]))))
    else $error("carry out bit wrong");
endmodule : bru_top
`default_nettype wire

// ---- verif/bru_top_test.sv ----
// self-checking bench for the byte rotate unit: corner ops, random ops, mid-run reset
// assumes bru_pkg is compiled first; inputs change 1 ns after each rising edge
`default_nettype none
module bru_top_test
  import bru_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic     i_mclk = 1'b0;
  logic     i_nrst;
  bru_req_s i_req;
  logic     o_done;
  bru_res_s o_res;
  bru_req_s prev;
  int       n_fail;
  int       n_tests;
  int       seed;

  // 125 MHz instruction clock
  always #4 i_mclk = ~i_mclk;

  bru_top dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req(i_req), .o_done(o_done), .o_res(o_res));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // expected result; refused requests give all enables low
  function automatic bru_res_s exp_res(input bru_req_s r);
    bru_res_s e;
    e = '0;
    case (r.op)
      BRU_OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
        e = '{1'b0, 1'b1, 1'b0, {r.mem[6:0], r.mem[7]}, r.carry};
      end
      BRU_OP_ROTATE_LEFT_THROUGH_CARRY: begin
        e = '{1'b1, 1'b0, 1'b1, {r.mem[6:0], r.carry}, r.mem[7]};
      end
      BRU_OP_ROTATE_LEFT_THROUGH_CARRY_TO_ACCUMULATOR: begin
        e = '{1'b0, 1'b1, 1'b1, {r.mem[6:0], r.carry}, r.mem[7]};
      end
      BRU_OP_ROTATE_RIGHT_IN_PLACE: begin
        e = '{1'b1, 1'b0, 1'b0, {r.mem[0], r.mem[7:1]}, r.carry};
      end
      BRU_OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
        e = '{1'b0, 1'b1, 1'b0, {r.mem[0], r.mem[7:1]}, r.carry};
      end
      BRU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        e = '{1'b1, 1'b0, 1'b1, {r.carry, r.mem[7:1]}, r.mem[0]};
      end
      default: begin
        e = '0;
      end
    endcase
    if (!r.valid) begin
      e = '0;
    end
    return e;
  endfunction : exp_res

  // outputs one edge after the request; data and carry only judged when taken
  task automatic check_out(input bru_req_s r);
    bru_res_s e;
    e = exp_res(r);
    check("done", {11'h000, o_done}, {11'h000, e.mem_we | e.acc_we});
    if (e.mem_we | e.acc_we) begin
      check("result", o_res, e);
    end else begin
      check("enables", {9'h000, o_res.mem_we, o_res.acc_we, o_res.carry_we}, 12'h000);
    end
  endtask : check_out

  // main sequence: 32 corner requests, then random ones, reset again at 300
  initial begin
    seed = 43;
    n_fail = 0;
    n_tests = 0;
    i_nrst = 1'b0;
    i_req = '0;
    prev = '0;
    repeat (8) @(posedge i_mclk);
    #1;
    check("reset result", o_res, 12'h000);
    check("reset done", {11'h000, o_done}, 12'h000);
    i_nrst = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge i_mclk);
      #1;
      check_out(prev);
      if (i < 32) begin
        i_req = '{~(i[4] & i[3]), bru_op_e'(i[2:0]), (i[3] ? 8'h81 : 8'h7e), i[4]};
      end else begin
        i_req = '{($random(seed) % 8) != 0, bru_op_e'(3'($random(seed))), 8'($random(seed)), 1'($random(seed))};
      end
      prev = i_req;
      if (i == 300) begin
        i_nrst = 1'b0;
        prev = '0;
        #1;
        check("async reset result", o_res, 12'h000);
        check("async reset done", {11'h000, o_done}, 12'h000);
      end
      if (i == 301) begin
        i_nrst = 1'b1;
      end
    end
    give_verdict();
  end

  // watchdog well past the expected 408 cycles
  initial begin
    #4800;
    n_fail++;
    give_verdict();
  end
endmodule : bru_top_test
`default_nettype wire
